/* File: include/fcie_pkg.sv */
// Constants, types and register map of the flash configuration block
// Overview of operation
// - Completion enable set: interrupt requested while command done flag is set.
// - Collision enable set: interrupt requested while a read clash error is flagged.
// - Erase everything request ignores software writes; set only by outside trigger.
// - Request sets only when outside trigger arrives while command done flag is 1.
// - Device clears erase everything request itself when the operation finishes.
// - Erase-all runs erase, verify, program security byte, then unsecure field.
// - Writing 1 to sector erase suspend suspends a running sector erase.
// - Reserved configuration bits 3 to 0 read zero and ignore writes.
// - Command done flag reads 0 while a command runs, 1 once completed.
// - Read clash error flagged when a busy resource is read while done flag is 0.
package fcie_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] FCIE_IDX_STATUS = 6'h00;
  localparam logic [5:0] FCIE_IDX_CONFIG = 6'h01;

  // Configuration register fields
  localparam int FCIE_CFG_DONE_IE = 7;
  localparam int FCIE_CFG_CLASH_IE = 6;
  localparam int FCIE_CFG_ERASE_REQ = 5;
  localparam int FCIE_CFG_SUSPEND = 4;
  localparam logic [7:0] FCIE_CFG_RESET = 8'h00;

  // Status register fields
  localparam int FCIE_ST_DONE = 7;
  localparam int FCIE_ST_CLASH = 6;
  localparam int FCIE_ST_SEC_LSB = 0;

  // Security field encodings
  localparam logic [1:0] FCIE_SEC_UNSECURE = 2'h2;
  localparam logic [1:0] FCIE_SEC_RESET = 2'h3;

  // Steps the erase-all sequencer asks the array controller to run
  typedef enum logic [1:0] {
    FCIE_STEP_ERASE = 2'h0,
    FCIE_STEP_VERIFY = 2'h1,
    FCIE_STEP_PROGRAM = 2'h2
  } fcie_step_e;

  typedef struct packed {
    logic valid;
    fcie_step_e step;
  } fcie_step_req_s;

  typedef struct packed {
    logic done;
    logic fail;
  } fcie_step_rsp_s;

endpackage : fcie_pkg

/* File: logic/fcie_erase_seq.sv */
// Erase-all sequencer: erase, verify, program security byte, unsecure
`timescale 1ns/10ps
`default_nettype none
module fcie_erase_seq
  import fcie_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Control
  input wire logic i_start,
  output logic o_busy,
  output logic o_finish,
  output logic o_unsecure,
  // Array controller steps
  output fcie_step_req_s o_step_req,
  input wire fcie_step_rsp_s i_step_rsp
);

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ERASE = 5'h02,
    S_VERIFY = 5'h04,
    S_PROGRAM = 5'h08,
    S_UNSEC = 5'h10
  } fcie_seq_e;

  fcie_seq_e state_q;
  fcie_seq_e state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        if (i_start) begin
          state_d = S_ERASE;
        end
      end
      S_ERASE: begin
        // A failed step abandons the sequence; security stays as it was
        if (i_step_rsp.done) begin
          state_d = i_step_rsp.fail ? S_IDLE : S_VERIFY;
        end
      end
      S_VERIFY: begin
        if (i_step_rsp.done) begin
          state_d = i_step_rsp.fail ? S_IDLE : S_PROGRAM;
        end
      end
      S_PROGRAM: begin
        if (i_step_rsp.done) begin
          state_d = i_step_rsp.fail ? S_IDLE : S_UNSEC;
        end
      end
      S_UNSEC: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    o_step_req.valid = (state_q == S_ERASE) || (state_q == S_VERIFY) ||
                       (state_q == S_PROGRAM);
    o_step_req.step = FCIE_STEP_ERASE;
    if (state_q == S_VERIFY) begin
      o_step_req.step = FCIE_STEP_VERIFY;
    end else if (state_q == S_PROGRAM) begin
      o_step_req.step = FCIE_STEP_PROGRAM;
    end
  end

  assign o_busy = (state_q != S_IDLE);
  assign o_unsecure = (state_q == S_UNSEC);
  assign o_finish = o_busy && (state_d == S_IDLE);

endmodule : fcie_erase_seq
`default_nettype wire

/* File: logic/fcie_flash_cfg.sv */
// Flash configuration register, status flags, interrupt and erase-all
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module fcie_flash_cfg
  import fcie_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Controller status
  input wire logic i_cmd_busy,
  input wire logic i_busy_resource_read,
  input wire logic i_sector_erase_active,
  input wire logic i_erase_all_trigger,
  input wire logic [1:0] i_security_load,
  // Controller control
  output logic o_sector_erase_suspend,
  output logic o_erase_all_busy,
  output logic [1:0] o_security_state_field,
  output fcie_step_req_s o_step_req,
  input wire fcie_step_rsp_s i_step_rsp,
  // Interrupt
  output logic o_irq
);

  // Byte-lane bits below the register index
  localparam int LANE_W = 2;

  // The index needs at least one bit above the byte-lane bits
  if (ADDR_W < LANE_W + 1) begin : g_addr_narrow
    $error("ADDR_W leaves no register index");
  end
  if (ADDR_W > 32) begin : g_addr_wide
    $error("ADDR_W is wider than the bus");
  end

  // The full index is compared, so no register aliases higher up
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [5:0] idx);
    hit = (a[ADDR_W-1:LANE_W] == (ADDR_W-LANE_W)'(idx));
  endfunction : hit

  logic ack_q;
  logic [31:0] readdata_q;
  logic done_ie_q;
  logic clash_ie_q;
  logic erase_req_q;
  logic suspend_q;
  logic clash_flag_q;
  logic [1:0] sec_q;
  logic sec_loaded_q;
  logic command_done_flag;
  logic seq_busy;
  logic seq_finish;
  logic seq_unsecure;
  logic seq_start;
  logic wr_cfg;
  logic wr_st;
  logic [7:0] cfg_view;
  logic [7:0] st_view;
  logic bus_req;
  logic bus_first;
  logic bus_accept;
  logic clash_clear;
  logic irq_done;
  logic irq_clash;

  // One wait state on every access keeps read data registered
  assign bus_req = i_read || i_write;
  assign bus_first = bus_req && !ack_q;
  assign bus_accept = bus_req && ack_q;
  assign o_waitrequest = bus_first;
  assign o_readdata = readdata_q;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_first;
    end
  end

  // Writes land on the edge where waitrequest is low
  assign wr_cfg = i_write && bus_accept && i_byteenable[0] &&
                  hit(i_address, FCIE_IDX_CONFIG);
  assign wr_st = i_write && bus_accept && i_byteenable[0] &&
                 hit(i_address, FCIE_IDX_STATUS);
  // Writing 0 to the clash bit leaves it alone
  assign clash_clear = wr_st && i_writedata[FCIE_ST_CLASH];

  // The erase-all job is itself a command, so it also holds the flag low
  assign command_done_flag = !i_cmd_busy && !seq_busy;

  // Bit 5 only shows the request; software has no path to set it
  assign cfg_view = {done_ie_q, clash_ie_q, erase_req_q, suspend_q,
                     4'h0};
  always_comb begin
    st_view = 8'h00;
    st_view[FCIE_ST_DONE] = command_done_flag;
    st_view[FCIE_ST_CLASH] = clash_flag_q;
    st_view[FCIE_ST_SEC_LSB +: 2] = sec_q;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      readdata_q <= 32'h0000_0000;
    end else if (i_read && bus_first) begin
      if (hit(i_address, FCIE_IDX_CONFIG)) begin
        readdata_q <= {24'h00_0000, cfg_view};
      end else if (hit(i_address, FCIE_IDX_STATUS)) begin
        readdata_q <= {24'h00_0000, st_view};
      end else begin
        readdata_q <= 32'h0000_0000;
      end
    end
  end

  // Interrupt enables, plain read/write bits
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      done_ie_q <= FCIE_CFG_RESET[FCIE_CFG_DONE_IE];
    end else if (wr_cfg) begin
      done_ie_q <= i_writedata[FCIE_CFG_DONE_IE];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      clash_ie_q <= FCIE_CFG_RESET[FCIE_CFG_CLASH_IE];
    end else if (wr_cfg) begin
      clash_ie_q <= i_writedata[FCIE_CFG_CLASH_IE];
    end
  end

  // Erase everything request: no software write path reaches it
  // A failed step also ends the job, so the bit never sticks at 1
  assign seq_start = i_erase_all_trigger && command_done_flag &&
                     !erase_req_q;
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      erase_req_q <= FCIE_CFG_RESET[FCIE_CFG_ERASE_REQ];
    end else if (seq_start) begin
      erase_req_q <= 1'b1;
    end else if (seq_finish) begin
      erase_req_q <= 1'b0;
    end
  end

  // Suspend is dropped by hardware once no sector erase is running;
  // a write of 1 in that same cycle still wins
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      suspend_q <= FCIE_CFG_RESET[FCIE_CFG_SUSPEND];
    end else if (wr_cfg) begin
      suspend_q <= i_writedata[FCIE_CFG_SUSPEND];
    end else if (!i_sector_erase_active) begin
      suspend_q <= 1'b0;
    end
  end
  assign o_sector_erase_suspend = suspend_q && i_sector_erase_active;

  // Read clash flag: sticky, write 1 to clear, a new clash beats the clear
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      clash_flag_q <= 1'b0;
    end else if (i_busy_resource_read && !command_done_flag) begin
      clash_flag_q <= 1'b1;
    end else if (clash_clear) begin
      clash_flag_q <= 1'b0;
    end
  end

  // Security field: stored byte is caught just after reset release
  // Caught once only, so later noise on the load bus cannot resecure
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sec_loaded_q <= 1'b0;
    end else begin
      sec_loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sec_q <= FCIE_SEC_RESET;
    end else if (seq_unsecure) begin
      sec_q <= FCIE_SEC_UNSECURE;
    end else if (!sec_loaded_q) begin
      sec_q <= i_security_load;
    end
  end
  assign o_security_state_field = sec_q;

  fcie_erase_seq u_seq (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_start(seq_start),
    .o_busy(seq_busy),
    .o_finish(seq_finish),
    .o_unsecure(seq_unsecure),
    .o_step_req(o_step_req),
    .i_step_rsp(i_step_rsp)
  );
  assign o_erase_all_busy = seq_busy;

  // Level request, held while either enabled condition stays true;
  // no edge is kept, so it falls as soon as both conditions fall
  assign irq_done = done_ie_q && command_done_flag;
  assign irq_clash = clash_ie_q && clash_flag_q;
  assign o_irq = irq_done || irq_clash;

endmodule : fcie_flash_cfg
`default_nettype wire

/* File: verification/fcie_flash_cfg_assertions.sv */
// Checker for bus wait timing, erase-all ordering and suspend gating
`timescale 1ns/10ps
`default_nettype none
module fcie_cfg_chk
  import fcie_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic i_cmd_busy,
  input wire logic i_erase_all_trigger,
  input wire logic i_sector_erase_active,
  input wire logic o_sector_erase_suspend,
  input wire logic o_erase_all_busy,
  input wire logic [1:0] o_security_state_field,
  input wire fcie_step_req_s o_step_req,
  input wire fcie_step_rsp_s i_step_rsp
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_at(fcie_step_e st);
    o_step_req.valid && o_step_req.step == st;
  endsequence
  sequence s_done(fcie_step_e st);
    s_at(st) ##0 (i_step_rsp.done && !i_step_rsp.fail);
  endsequence
  a_one_wait:
    assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("wait state not one cycle");
  a_susp_gate:
    assert property (o_sector_erase_suspend |-> i_sector_erase_active)
    else $error("suspend without sector erase");
  a_susp_by_write:
    assert property ($rose(o_sector_erase_suspend) |-> $past(i_write))
    else $error("suspend rose without a write");
  a_busy_refuse:
    assert property (i_cmd_busy && !o_erase_all_busy |=> !o_erase_all_busy)
    else $error("erase-all started during command");
  a_trig_start:
    assert property (i_erase_all_trigger && !i_cmd_busy && !o_erase_all_busy
      |=> s_at(FCIE_STEP_ERASE)) else $error("erase step missing");
  a_erase_verify:
    assert property (s_done(FCIE_STEP_ERASE) |=> s_at(FCIE_STEP_VERIFY))
    else $error("verify step missing");
  a_verify_prog:
    assert property (s_done(FCIE_STEP_VERIFY) |=> s_at(FCIE_STEP_PROGRAM))
    else $error("program step missing");
  a_prog_unsec:
    assert property (s_done(FCIE_STEP_PROGRAM) |-> ##2
      (o_security_state_field == FCIE_SEC_UNSECURE && !o_erase_all_busy))
    else $error("unsecure state missing");
  a_sec_still:
    assert property (!o_erase_all_busy && !$past(o_erase_all_busy) &&
      $past(i_nrst, 2) |-> $stable(o_security_state_field))
    else $error("security changed while idle");
endmodule : fcie_cfg_chk
bind fcie_flash_cfg fcie_cfg_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* File: verification/tb_flash_config_irq_erase_ctrl.sv */
// Testbench for the flash configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_flash_config_irq_erase_ctrl import fcie_pkg::*;;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_read = 1'b0, i_write = 1'b0, i_cmd_busy = 1'b0;
  logic i_busy_resource_read = 1'b0, i_sector_erase_active = 1'b0;
  logic i_erase_all_trigger = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic [3:0] i_byteenable = 4'hf;
  logic [31:0] i_writedata = 32'h0, o_readdata;
  // Stored value differs from the reset value so the load is seen
  logic [1:0] i_security_load = 2'h1, o_security_state_field;
  logic o_waitrequest, o_sector_erase_suspend, o_erase_all_busy, o_irq;
  fcie_step_req_s o_step_req;
  fcie_step_rsp_s i_step_rsp = '0;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] q;
  always #12.5 i_mclk = ~i_mclk;
  fcie_flash_cfg #(.ADDR_W(8)) dut (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_byteenable(i_byteenable),
    .i_writedata(i_writedata),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .i_cmd_busy(i_cmd_busy),
    .i_busy_resource_read(i_busy_resource_read),
    .i_sector_erase_active(i_sector_erase_active),
    .i_erase_all_trigger(i_erase_all_trigger),
    .i_security_load(i_security_load),
    .o_sector_erase_suspend(o_sector_erase_suspend),
    .o_erase_all_busy(o_erase_all_busy),
    .o_security_state_field(o_security_state_field),
    .o_step_req(o_step_req),
    .i_step_rsp(i_step_rsp),
    .o_irq(o_irq)
  );
  task automatic finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // Extra edge at the end lets a write land before anything is sampled
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_write <= wr;
    i_read <= !wr;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    q = o_readdata[7:0];
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (o_waitrequest !== 1'b0) begin
      fail_count++;
      finish_test();
    end
    @(posedge i_mclk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask : rd
  task automatic t_regs;
    rd(8'h04, 8'h00, "cfg reset");
    rd(8'h00, 8'h81, "status reset");
    i_sector_erase_active <= 1'b1;
    bus(1'b1, 8'h04, 8'hff);
    rd(8'h04, 8'hd0, "cfg write");
    chk("suspend", 8'h01, 8'(o_sector_erase_suspend));
    i_byteenable <= 4'he;
    bus(1'b1, 8'h04, 8'h00);
    i_byteenable <= 4'hf;
    rd(8'h04, 8'hd0, "lane off");
    i_sector_erase_active <= 1'b0;
    rd(8'h04, 8'hc0, "suspend clear");
    bus(1'b1, 8'h08, 8'hff);
    rd(8'h08, 8'h00, "unmapped");
    $display("test regs done");
  endtask : t_regs
  task automatic t_irq;
    bus(1'b1, 8'h04, 8'h00);
    chk("irq off", 8'h00, 8'(o_irq));
    bus(1'b1, 8'h04, 8'h80);
    chk("irq done", 8'h01, 8'(o_irq));
    i_cmd_busy <= 1'b1;
    rd(8'h00, 8'h01, "busy status");
    chk("irq busy", 8'h00, 8'(o_irq));
    bus(1'b1, 8'h04, 8'h40);
    i_busy_resource_read <= 1'b1;
    @(posedge i_mclk);
    i_busy_resource_read <= 1'b0;
    @(posedge i_mclk);
    chk("irq clash", 8'h01, 8'(o_irq));
    rd(8'h00, 8'h41, "clash flag");
    bus(1'b1, 8'h00, 8'h00);
    chk("clash kept", 8'h01, 8'(o_irq));
    bus(1'b1, 8'h00, 8'h40);
    chk("irq cleared", 8'h00, 8'(o_irq));
    i_cmd_busy <= 1'b0;
    bus(1'b1, 8'h04, 8'h00);
    $display("test irq done");
  endtask : t_irq
  task automatic pulse_trigger;
    i_erase_all_trigger <= 1'b1;
    @(posedge i_mclk);
    i_erase_all_trigger <= 1'b0;
  endtask : pulse_trigger
  task automatic step(input logic [1:0] k, input logic fl);
    @(posedge i_mclk);
    chk("step", {6'h01, k}, 8'(o_step_req));
    i_step_rsp <= {1'b1, fl};
    @(posedge i_mclk);
    i_step_rsp <= 2'b00;
  endtask : step
  task automatic t_erase;
    i_cmd_busy <= 1'b1;
    pulse_trigger();
    @(posedge i_mclk);
    chk("refused", 8'h00, 8'(o_erase_all_busy));
    i_cmd_busy <= 1'b0;
    pulse_trigger();
    rd(8'h04, 8'h20, "request bit");
    chk("erase busy", 8'h01, 8'(o_erase_all_busy));
    rd(8'h00, 8'h01, "done low in erase");
    step(2'h0, 1'b0);
    step(2'h1, 1'b1);
    rd(8'h04, 8'h00, "abort request");
    chk("abort busy", 8'h00, 8'(o_erase_all_busy));
    chk("abort security", 8'h01, 8'(o_security_state_field));
    pulse_trigger();
    for (int k = 0; k < 3; k++) begin
      step(k[1:0], 1'b0);
    end
    repeat (2) @(posedge i_mclk);
    chk("security", 8'h02, 8'(o_security_state_field));
    rd(8'h04, 8'h00, "request clear");
    $display("test erase done");
  endtask : t_erase
  initial begin
    repeat (12) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_regs();
    t_irq();
    t_erase();
    finish_test();
  end
endmodule : tb_flash_config_irq_erase_ctrl
`default_nettype wire
